// ==== design/alu_pkg.sv ====
// constants, operation codes and carriers for the 8-bit alu and flags register
// assumes the instruction sequencer decodes opcodes into alu_op_e
package alu_pkg;

	localparam logic [8:0] FLAGS_ADDR     = 9'h003; // flags register data address
	localparam int         FLAG_CARRY     = 0;
	localparam int         FLAG_NIBBLE    = 1;
	localparam int         FLAG_ZERO      = 2;
	localparam int         FLAG_SLEEP_N   = 3;
	localparam int         FLAG_WDOG_N    = 4;
	localparam int         FLAG_PAGE_LO   = 5;
	localparam int         FLAG_PAGE_HI   = 6;
	localparam int         FLAG_IND_PAGE  = 7;
	localparam logic [7:0] FLAGS_RESET    = 8'h18; // page bits 0, reset-cause bits 1, arithmetic flags 0
	localparam logic [7:0] WREG_RESET     = 8'h00;
	localparam logic [7:0] ARITH_MASK     = 8'h07; // bits the operation owns
	localparam logic [7:0] CAUSE_MASK     = 8'h18; // bits only hardware events change
	localparam logic [7:0] CLEAR_KEEP     = 8'h1b; // bits a whole-register clear leaves alone

	typedef enum logic [3:0] {
		OP_NONE,
		OP_MOVE_TO_WREG,     // memory operand to working register, no flags
		OP_MOVE_TO_REG,      // working register to memory, no flags
		OP_ADD,              // operand + working register
		OP_WREG_MINUS_REG,   // working register - operand
		OP_REG_MINUS_WREG,   // operand - working register
		OP_AND_LITERAL,
		OP_XOR_LITERAL,
		OP_SHIFT_LEFT,       // rotate through carry
		OP_SHIFT_RIGHT,
		OP_BIT_CLEAR,
		OP_BIT_SET,
		OP_NIBBLE_SWAP,
		OP_CLEAR             // clear destination, sets zero
	} alu_op_e;

	typedef struct packed {
		alu_op_e    op;
		logic       to_reg;   // 1: result goes to memory operand, 0: working register
		logic [8:0] addr;     // resolved 9-bit data address of the operand
		logic [7:0] operand;  // memory operand value
		logic [7:0] literal;  // instruction constant
		logic [2:0] bit_sel;  // bit index for bit set and clear
	} alu_req_s;

	typedef struct packed {
		logic       we;
		logic [8:0] addr;
		logic [7:0] data;
	} mem_wr_s;

endpackage : alu_pkg

// ==== design/alu_core.sv ====
// 8-bit alu with working register, flags register and reset-cause tracking
// assumes the sequencer presents one request per instruction cycle with EXEC high
`timescale 1ns/1ps
module alu_core
	import alu_pkg::*;
(
	// clock and reset
	input  wire logic     CLK,
	input  wire logic     ARST_N,
	// instruction request from the sequencer
	input  wire logic     EXEC,
	input  alu_req_s      REQ,
	// hardware events, single-cycle pulses from core logic
	input  wire logic     WATCHDOG_KICK,
	input  wire logic     WATCHDOG_EXPIRED,
	input  wire logic     SLEEP_ENTER,
	// address forming inputs
	input  wire logic [6:0] DIRECT_OFFSET,
	input  wire logic [7:0] POINTER_VALUE,
	// results
	output mem_wr_s       MEM_WR,
	output logic [7:0]    WREG,
	output logic [7:0]    FLAGS,
	output logic [1:0]    DIRECT_BANK,
	output logic [8:0]    DIRECT_ADDR,
	output logic [8:0]    INDIRECT_ADDR
);

	logic [7:0] wreg_q, wreg_d;
	logic [7:0] flags_q, flags_d;
	mem_wr_s    mem_wr_q, mem_wr_d;
	logic [8:0] direct_addr_q, indirect_addr_q;

	// operand selection and raw arithmetic, 9-bit full sums and 5-bit nibble sums so carry falls out
	logic [8:0] sum_full;
	logic [4:0] sum_nib;
	logic [7:0] sub_a, sub_b;
	logic [8:0] sub_full;
	logic [4:0] sub_nib;
	logic       is_sub, is_rev;
	assign is_rev   = (REQ.op == OP_WREG_MINUS_REG);
	assign is_sub   = is_rev || (REQ.op == OP_REG_MINUS_WREG);
	assign sub_a    = is_rev ? wreg_q : REQ.operand;
	assign sub_b    = is_rev ? REQ.operand : wreg_q;
	// subtract as a + ~b + 1, carry set means no borrow
	assign sub_full = {1'b0, sub_a} + {1'b0, ~sub_b} + 9'h001;
	assign sub_nib  = {1'b0, sub_a[3:0]} + {1'b0, ~sub_b[3:0]} + 5'h01;
	assign sum_full = {1'b0, REQ.operand} + {1'b0, wreg_q};
	assign sum_nib  = {1'b0, REQ.operand[3:0]} + {1'b0, wreg_q[3:0]};

	// result and flag effects of each operation
	// logic ops touch zero only and shifts touch carry only, so the other flags survive
	logic [7:0] result;
	logic       aff_zero, aff_carry, aff_nib;
	logic       new_carry, new_nib;
	logic [7:0] bit_mask;
	assign bit_mask = 8'h01 << REQ.bit_sel;

	always_comb begin
		result    = REQ.operand;
		aff_zero  = 1'b0;
		aff_carry = 1'b0;
		aff_nib   = 1'b0;
		new_carry = flags_q[FLAG_CARRY];
		new_nib   = flags_q[FLAG_NIBBLE];
		unique case (REQ.op)
			OP_NONE, OP_MOVE_TO_WREG: begin
				result = REQ.operand;
			end
			OP_MOVE_TO_REG: begin
				result = wreg_q;
			end
			OP_ADD: begin
				result    = sum_full[7:0];
				{aff_zero, aff_carry, aff_nib} = 3'b111;
				new_carry = sum_full[8];
				new_nib   = sum_nib[4];
			end
			OP_WREG_MINUS_REG, OP_REG_MINUS_WREG: begin
				result    = sub_full[7:0];
				{aff_zero, aff_carry, aff_nib} = 3'b111;
				new_carry = sub_full[8];
				new_nib   = sub_nib[4];
			end
			OP_AND_LITERAL: begin
				result   = wreg_q & REQ.literal;
				aff_zero = 1'b1;
			end
			OP_XOR_LITERAL: begin
				result   = wreg_q ^ REQ.literal;
				aff_zero = 1'b1;
			end
			OP_SHIFT_LEFT: begin
				result    = {REQ.operand[6:0], flags_q[FLAG_CARRY]};
				aff_carry = 1'b1;
				new_carry = REQ.operand[7];
			end
			OP_SHIFT_RIGHT: begin
				result    = {flags_q[FLAG_CARRY], REQ.operand[7:1]};
				aff_carry = 1'b1;
				new_carry = REQ.operand[0];
			end
			OP_BIT_CLEAR: begin
				result = REQ.operand & ~bit_mask;
			end
			OP_BIT_SET: begin
				result = REQ.operand | bit_mask;
			end
			OP_NIBBLE_SWAP: begin
				result = {REQ.operand[3:0], REQ.operand[7:4]};
			end
			OP_CLEAR: begin
				result   = 8'h00;
				aff_zero = 1'b1;
			end
			default: begin
				result = REQ.operand; // two spare opcodes fall back to the operand
			end
		endcase
	end

	// flags register answers at one offset in every bank, so only the low seven bits count
	function automatic logic is_flags_addr(input logic [8:0] addr);
		return addr[6:0] == FLAGS_ADDR[6:0];
	endfunction : is_flags_addr

	// destination decode; a write aimed at the flags register never leaves the block
	logic to_flags, wr_mem, wr_wreg, arith_aff;
	assign to_flags  = REQ.to_reg && is_flags_addr(REQ.addr); // mirrored in every bank
	assign wr_mem    = EXEC && REQ.to_reg && (REQ.op != OP_NONE) && (REQ.op != OP_MOVE_TO_WREG);
	assign wr_wreg   = EXEC && !REQ.to_reg && (REQ.op != OP_NONE) && (REQ.op != OP_MOVE_TO_REG);
	assign arith_aff = aff_zero || aff_carry || aff_nib;

	// flags next value: software write first, then operation flags, then events
	// later stages overwrite earlier ones, so events can never be undone by software
	logic [7:0] sw_flags, op_flags, write_mask;
	// a flag-affecting op to the flags register may not write the arithmetic bits
	assign write_mask = ~CAUSE_MASK & (arith_aff ? ~ARITH_MASK : 8'hff);
	assign sw_flags   = (wr_mem && to_flags) ?
	                    ((flags_q & ~write_mask) | (result & write_mask)) : flags_q;

	always_comb begin
		op_flags = sw_flags;
		if (EXEC && REQ.op == OP_CLEAR && REQ.to_reg && to_flags) begin
			op_flags = flags_q & CLEAR_KEEP; // top three cleared, cause bits kept
		end
		if (EXEC && aff_zero) begin
			op_flags[FLAG_ZERO] = (result == 8'h00);
		end
		if (EXEC && aff_nib) begin
			op_flags[FLAG_NIBBLE] = new_nib;
		end
		if (EXEC && aff_carry) begin
			op_flags[FLAG_CARRY] = new_carry;
		end
		flags_d = op_flags;
		// cause bits move only on hardware events; expiry outranks a same-cycle kick
		if (WATCHDOG_KICK) begin
			flags_d[FLAG_WDOG_N]  = 1'b1;
			flags_d[FLAG_SLEEP_N] = 1'b1;
		end
		if (SLEEP_ENTER) begin
			flags_d[FLAG_WDOG_N]  = 1'b1;
			flags_d[FLAG_SLEEP_N] = 1'b0;
		end
		if (WATCHDOG_EXPIRED) begin
			flags_d[FLAG_WDOG_N] = 1'b0;
		end
	end

	// working register and memory write-back
	// the working register has no data address, so only wr_wreg can load it
	assign wreg_d          = wr_wreg ? result : wreg_q;
	assign mem_wr_d.we     = wr_mem && !to_flags;
	assign mem_wr_d.addr   = REQ.addr;
	assign mem_wr_d.data   = result;

	// bank and pointer address forming from the next flags value
	// using the next flags keeps the addresses in step with a same-cycle page write
	logic [8:0] direct_addr_d, indirect_addr_d;
	assign direct_addr_d   = {flags_d[FLAG_PAGE_HI:FLAG_PAGE_LO], DIRECT_OFFSET};
	assign indirect_addr_d = {flags_d[FLAG_IND_PAGE], POINTER_VALUE};

	// one register stage; result and flags land on the same edge
	// outputs come straight from these flops, so a consumer never sees a half-updated set
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wreg_q          <= WREG_RESET;
			flags_q         <= FLAGS_RESET; // power-up sets both cause bits
			mem_wr_q        <= '0;
			direct_addr_q   <= '0;
			indirect_addr_q <= '0;
		end else begin
			wreg_q          <= wreg_d;
			flags_q         <= flags_d;
			mem_wr_q        <= mem_wr_d;
			direct_addr_q   <= direct_addr_d;
			indirect_addr_q <= indirect_addr_d;
		end
	end

	assign WREG          = wreg_q;
	assign FLAGS         = flags_q;
	assign MEM_WR        = mem_wr_q;
	assign DIRECT_BANK   = flags_q[FLAG_PAGE_HI:FLAG_PAGE_LO];
	assign DIRECT_ADDR   = direct_addr_q;
	assign INDIRECT_ADDR = indirect_addr_q;

endmodule : alu_core

// ==== verification/alu_core_assertions.sv ====
// port assertions for alu_core
// assumes the bind below reaches every alu_core
`timescale 1ns/1ps
module alu_core_chk
	import alu_pkg::*;
(
	// clock, reset and request
	input wire logic       CLK,
	input wire logic       ARST_N,
	input wire logic       EXEC,
	input alu_req_s        REQ,
	// hardware events
	input wire logic       WATCHDOG_KICK,
	input wire logic       WATCHDOG_EXPIRED,
	input wire logic       SLEEP_ENTER,
	// address forming inputs
	input wire logic [6:0] DIRECT_OFFSET,
	input wire logic [7:0] POINTER_VALUE,
	// results
	input mem_wr_s         MEM_WR,
	input wire logic [7:0] WREG,
	input wire logic [7:0] FLAGS,
	input wire logic [1:0] DIRECT_BANK,
	input wire logic [8:0] DIRECT_ADDR,
	input wire logic [8:0] INDIRECT_ADDR
);
	// no event this cycle; request aimed at flags in any bank
	wire quiet = !(WATCHDOG_KICK || WATCHDOG_EXPIRED || SLEEP_ENTER);
	wire to_fl = REQ.to_reg && REQ.addr[6:0] == 7'h03;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	chk_bank_sel: assert property (DIRECT_BANK == FLAGS[6:5]) else $error("bank");
	chk_dir_addr: assert property ($past(ARST_N) |->
		DIRECT_ADDR == {FLAGS[6:5], $past(DIRECT_OFFSET)}) else $error("direct address");
	chk_ind_addr: assert property ($past(ARST_N) |->
		INDIRECT_ADDR == {FLAGS[7], $past(POINTER_VALUE)}) else $error("indirect address");
	chk_cause_keep: assert property (quiet |=> $stable(FLAGS[4:3])) else $error("cause bits");
	chk_expire_evt: assert property (WATCHDOG_EXPIRED |=>
		!FLAGS[4] && FLAGS[3] == $past(FLAGS[3])) else $error("expiry");
	chk_sleep_evt: assert property (SLEEP_ENTER && !WATCHDOG_EXPIRED |=>
		FLAGS[4:3] == 2'b10) else $error("sleep");
	chk_kick_evt: assert property (WATCHDOG_KICK && !WATCHDOG_EXPIRED && !SLEEP_ENTER |=>
		FLAGS[4:3] == 2'b11) else $error("kick");
	chk_no_flag_wr: assert property (MEM_WR.we |-> MEM_WR.addr[6:0] != 7'h03) else $error("flags on bus");
	chk_sub_mem: assert property (EXEC && REQ.op == OP_REG_MINUS_WREG && REQ.to_reg && !to_fl |=>
		MEM_WR.we && MEM_WR.data == 8'($past(REQ.operand) - $past(WREG))) else $error("sub");
	chk_clear_flags: assert property (EXEC && REQ.op == OP_CLEAR && to_fl && quiet |=>
		FLAGS == {3'b000, $past(FLAGS[4:3]), 1'b1, $past(FLAGS[1:0])}) else $error("clear");
	chk_bit_keep: assert property (EXEC && !to_fl &&
		REQ.op inside {OP_BIT_CLEAR, OP_BIT_SET, OP_NIBBLE_SWAP} |=> $stable(FLAGS[2:0]))
		else $error("bit op flags");
endmodule : alu_core_chk
bind alu_core alu_core_chk alu_core_chk_i (.CLK, .ARST_N, .EXEC, .WATCHDOG_KICK, .WATCHDOG_EXPIRED,
	.SLEEP_ENTER, .REQ, .MEM_WR, .DIRECT_OFFSET, .POINTER_VALUE, .WREG, .FLAGS, .DIRECT_BANK,
	.DIRECT_ADDR, .INDIRECT_ADDR);

// ==== verification/seq_mem_model.sv ====
// data memory behind the alu and the software cause decode
// assumes one write a cycle on MEM_WR
`timescale 1ns/1ps
module seq_mem_model
	import alu_pkg::*;
(
	// clock and memory side
	input  wire logic       CLK,
	input  mem_wr_s         MEM_WR,
	input  wire logic [8:0] RD_ADDR,
	output logic [7:0]      RD_DATA,
	// cause decode
	input  wire logic [7:0] FLAGS,
	output logic [1:0]      CAUSE
);
	logic [7:0] mem_q [512];
	// preset pattern so a stale read is all zero only at addresses 0 and 256
	initial for (int i = 0; i < 512; i++) mem_q[i] = 8'(i * 37);
	always @(posedge CLK) if (MEM_WR.we) mem_q[MEM_WR.addr] <= MEM_WR.data;
	assign RD_DATA = mem_q[RD_ADDR];
	// 0 wake from sleep, 1 overflow while running, 3 power-on
	assign CAUSE = FLAGS[4:3];
endmodule : seq_mem_model

// ==== verification/test_acc_alu_status_flags.sv ====
// self-checking bench for alu_core against an integer model
// assumes alu_pkg and the memory model are compiled first
`timescale 1ns/1ps
module test_acc_alu_status_flags;
	import alu_pkg::*;
	logic        CLK = 0, ARST_N = 0, EXEC = 0, kick = 0, expd = 0, slp = 0;
	alu_req_s    req = '0;
	mem_wr_s     mw;
	logic [6:0]  offs = '0;
	logic [7:0]  ptr = '0, rd, wr, fg;
	logic [1:0]  bank, cause;
	logic [8:0]  da, ia;
	logic [31:0] rnd = 32'ha35bb818;
	logic [2:0]  ev [4] = '{3'b100, 3'b010, 3'b100, 3'b001};
	logic [1:0]  cx [4] = '{2'b01, 2'b10, 2'b00, 2'b11};
	int          error_cnt = 0, tests_run = 0, cyc = 0, w = 0, f = 8'h18;
	alu_core alu_core_i (.CLK, .ARST_N, .EXEC, .REQ(req), .WATCHDOG_KICK(kick), .WATCHDOG_EXPIRED(expd),
		.SLEEP_ENTER(slp), .DIRECT_OFFSET(offs), .POINTER_VALUE(ptr), .MEM_WR(mw), .WREG(wr),
		.FLAGS(fg), .DIRECT_BANK(bank), .DIRECT_ADDR(da), .INDIRECT_ADDR(ia));
	seq_mem_model seq_mem_model_i (.CLK, .MEM_WR(mw), .RD_ADDR(req.addr), .RD_DATA(rd), .FLAGS(fg),
		.CAUSE(cause));
	always #12.5 CLK = ~CLK;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction : lfsr
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// one random instruction, model result, compare one cycle later
	task automatic run_op;
		alu_op_e op;
		logic tr, fl;
		logic [8:0] a;
		int o, r, c, d, e, nf;
		rnd = lfsr(rnd);
		op = alu_op_e'(rnd[27:24] % 14);
		fl = op inside {OP_ADD, OP_WREG_MINUS_REG, OP_REG_MINUS_WREG, OP_CLEAR, OP_MOVE_TO_REG} && rnd[9:8] == 0;
		a = fl ? FLAGS_ADDR : {rnd[11:10], 2'b01, rnd[4:0]};
		tr = op inside {OP_MOVE_TO_REG, OP_BIT_CLEAR, OP_BIT_SET} || fl
			|| rnd[5] && !(op inside {OP_NONE, OP_MOVE_TO_WREG, OP_AND_LITERAL, OP_XOR_LITERAL});
		ptr = rnd[31:24];
		offs = rnd[22:16];
		req = '{op, tr, a, 8'h00, rnd[15:8], rnd[2:0]};
		EXEC = 1;
		#1 req.operand = fl ? f[7:0] : rd;
		o = req.operand;
		r = w;
		c = f[0];
		d = f[1];
		e = f[2];
		case (op)
			OP_ADD: begin r = o + w; c = r > 255; d = o % 16 + w % 16 > 15; end
			OP_WREG_MINUS_REG: begin r = w - o; c = w >= o; d = w % 16 >= o % 16; end
			OP_REG_MINUS_WREG: begin r = o - w; c = o >= w; d = o % 16 >= w % 16; end
			OP_AND_LITERAL: r = w & req.literal;
			OP_XOR_LITERAL: r = w ^ req.literal;
			OP_SHIFT_LEFT: begin r = o << 1 | c; c = o >> 7; end
			OP_SHIFT_RIGHT: begin r = o >> 1 | c << 7; c = o & 1; end
			OP_BIT_CLEAR: r = o & ~(1 << req.bit_sel);
			OP_BIT_SET: r = o | 1 << req.bit_sel;
			OP_NIBBLE_SWAP: r = o << 4 | o >> 4;
			OP_MOVE_TO_WREG: r = o;
			OP_CLEAR: r = 0;
			default: r = w;
		endcase
		r &= 255;
		if (op inside {OP_ADD, OP_WREG_MINUS_REG, OP_REG_MINUS_WREG, OP_AND_LITERAL, OP_XOR_LITERAL, OP_CLEAR})
			e = r == 0;
		nf = f & 8'hf8 | e << 2 | d << 1 | c;
		if (fl) f = op == OP_MOVE_TO_REG ? r & 8'he7 | f & 8'h18 : r & 8'he0 | nf & 8'h1f;
		else f = nf;
		if (!tr) w = r;
		@(negedge CLK);
		check(wr, w[7:0]);
		check(fg, f[7:0]);
		check(mw.we, tr && !fl);
		if (tr && !fl) check(mw, {1'b1, a, r[7:0]});
		check(bank, f[6:5]);
		check(da, {f[6:5], offs});
		check(ia, {f[7], ptr});
	endtask : run_op
	// hang guard, a few hundred cycles are expected
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 1000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(negedge CLK);
		ARST_N = 1;
		@(negedge CLK);
		check(wr, WREG_RESET);
		check(fg, FLAGS_RESET);
		check(cause, 2'b11);
		repeat (300) run_op();
		EXEC = 0;
		// expiry, sleep, expiry again, then kick
		foreach (ev[i]) begin
			{expd, slp, kick} = ev[i];
			@(negedge CLK);
			{expd, slp, kick} = 3'b000;
			f[4:3] = cx[i];
			check(fg, f[7:0]);
			check(cause, cx[i]);
			check(wr, w[7:0]);
			check(mw.we, 1'b0);
			@(negedge CLK);
		end
		wrap_up();
	end
endmodule : test_acc_alu_status_flags
